// ### fspc_pkg.sv
// Package for the flash self-programming control block: offsets, fields, timing
package fspc_pkg;
	// Register byte offsets
	localparam logic [11:0] REG_MODE     = 12'h000;
	localparam logic [11:0] REG_CMD      = 12'h004;
	localparam logic [11:0] REG_ADDR     = 12'h008;
	localparam logic [11:0] REG_WDATA    = 12'h00c;
	localparam logic [11:0] REG_STATUS   = 12'h010;
	localparam logic [11:0] REG_SECURITY = 12'h014;
	localparam logic [11:0] REG_RDATA    = 12'h018;

	// Commands written to the flash command register
	localparam logic [7:0] CMD_NONE  = 8'h00;
	localparam logic [7:0] CMD_WRITE = 8'h01;
	localparam logic [7:0] CMD_ERASE = 8'h02;
	localparam logic [7:0] CMD_READ  = 8'h03;

	// Field positions
	localparam int MODE_ENTER_BIT = 0;
	localparam int SEC_LOCK_BIT   = 0;
	localparam int ST_BUSY_BIT    = 0;
	localparam int ST_MODE_BIT    = 1;
	localparam int ST_PROT_BIT    = 2;
	localparam int ST_LOCK_BIT    = 3;

	// Data values
	localparam logic [7:0]  BLANK_BYTE = 8'hff;
	localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;

	// Timing
	localparam int CLK_HZ          = 40_000_000;
	localparam int WAKE_US         = 10;
	localparam int WAKE_EXTRA_CLKS = 2;
	localparam int WAKE_CYCLES     = (WAKE_US * CLK_HZ) / 1_000_000 + WAKE_EXTRA_CLKS;
	// Edges lost between the HALT and the wake count: two sync flops and the state hop
	localparam int HALT_SYNC_CLKS  = 3;
	localparam int OP_CYCLES       = 8;

	typedef enum logic [2:0] {
		FSPC_NORMAL,
		FSPC_WAIT_HALT,
		FSPC_WAKE,
		FSPC_IDLE,
		FSPC_WRITE,
		FSPC_ERASE,
		FSPC_READ
	} fspc_state_e;
endpackage : fspc_pkg

// ### fspc_ctrl.sv
// Flash self-programming sequencer with APB registers and CPU stall control
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module fspc_ctrl #(
	parameter int BLOCKS      = 4,
	parameter int BLOCK_BYTES = 16,
	parameter int WAKE_CYCLES = fspc_pkg::WAKE_CYCLES
) (
	input  wire logic        pclk,         // Bus clock, 40 MHz
	input  wire logic        presetn,      // Asynchronous reset, active low
	input  wire logic        psel,         // APB select
	input  wire logic        penable,      // APB access phase
	input  wire logic        pwrite,       // APB direction
	input  wire logic [11:0] paddr,        // APB byte address
	input  wire logic [31:0] pwdata,       // APB write data
	output logic      [31:0] prdata,       // APB read data
	output logic             pready,       // APB ready
	output logic             pslverr,      // APB error, unmapped address
	input  wire logic        cpu_halt,     // CPU executed HALT
	input  wire logic        irq_req,      // Interrupt request from sources
	output logic             irq_ack_ok,   // Interrupt may be acknowledged
	output logic             irq_pending,  // Request held during mode
	output logic             cpu_stall,    // Stall instruction fetch
	output logic             halt_release, // Wake pulse for the CPU
	output logic             pin_hold,     // Keep pins as in halt standby
	output logic             ram_req       // System RAM request, never used
);
	localparam int DEPTH = BLOCKS * BLOCK_BYTES;
	localparam int AW    = $clog2(DEPTH);
	localparam int CW    = 16;

	typedef struct packed {
		fspc_pkg::fspc_state_e state;
		logic [CW-1:0]         cnt;
		logic [7:0]            cmd;
		logic [AW-1:0]         addr;
		logic [7:0]            wdata;
		logic [7:0]            rdata;
		logic                  lock;
		logic                  prot_err;
		logic                  irq_pend;
		logic                  rel;
		logic [31:0]           prdata;
	} fspc_state_s;

	fspc_state_s   s_q, s_d;
	logic [7:0]    mem_q [DEPTH];
	logic          mem_we;
	logic [AW-1:0] mem_wa;
	logic [7:0]    mem_wd;
	logic          era_we;
	logic          wr_acc, rd_acc, busy, mode;
	logic          halt_s1_q, halt_s2_q, irq_s1_q, irq_s2_q;

	// Two-stage synchronisers for the CPU side strobes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_s1_q <= 1'b0;
			halt_s2_q <= 1'b0;
			irq_s1_q  <= 1'b0;
			irq_s2_q  <= 1'b0;
		end else begin
			halt_s1_q <= cpu_halt;
			halt_s2_q <= halt_s1_q;
			irq_s1_q  <= irq_req;
			irq_s2_q  <= irq_s1_q;
		end
	end

	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && penable && !pwrite;
	assign busy   = s_q.state inside {fspc_pkg::FSPC_WRITE, fspc_pkg::FSPC_ERASE, fspc_pkg::FSPC_READ};
	assign mode   = s_q.state != fspc_pkg::FSPC_NORMAL;

	// Block of the current address, used for erase decode
	function automatic logic [AW-1:0] blk_base(input logic [AW-1:0] a);
		blk_base = a - AW'(a % AW'(BLOCK_BYTES));
	endfunction : blk_base

	// Next state of the whole block
	always_comb begin
		s_d     = s_q;
		s_d.rel = 1'b0;
		mem_we  = 1'b0;
		mem_wa  = s_q.addr;
		mem_wd  = s_q.wdata;
		era_we  = 1'b0;
		// Register writes; command and pointers ignored while busy
		if (wr_acc && !busy) begin
			case (paddr)
				fspc_pkg::REG_MODE: begin
					if (pwdata[fspc_pkg::MODE_ENTER_BIT] && !mode) begin
						s_d.state = fspc_pkg::FSPC_WAIT_HALT;
					end else if (!pwdata[fspc_pkg::MODE_ENTER_BIT] && mode) begin
						s_d.state = fspc_pkg::FSPC_NORMAL;
					end
				end
				fspc_pkg::REG_CMD:      s_d.cmd   = pwdata[7:0];
				fspc_pkg::REG_ADDR:     s_d.addr  = pwdata[AW-1:0];
				fspc_pkg::REG_WDATA:    s_d.wdata = pwdata[7:0];
				// Lock is one way; only reset clears it
				fspc_pkg::REG_SECURITY: s_d.lock  = s_q.lock | pwdata[fspc_pkg::SEC_LOCK_BIT];
				fspc_pkg::REG_STATUS: begin
					if (pwdata[fspc_pkg::ST_PROT_BIT]) begin
						s_d.prot_err = 1'b0;
					end
				end
				default: ;
			endcase
		end
		// Read data captured in the setup cycle, so access takes no wait
		if (psel && !penable && !pwrite) begin
			case (paddr)
				fspc_pkg::REG_MODE:     s_d.prdata = {31'h0, mode};
				fspc_pkg::REG_CMD:      s_d.prdata = {24'h0, s_q.cmd};
				fspc_pkg::REG_ADDR:     s_d.prdata = 32'(s_q.addr);
				fspc_pkg::REG_WDATA:    s_d.prdata = {24'h0, s_q.wdata};
				fspc_pkg::REG_SECURITY: s_d.prdata = {31'h0, s_q.lock};
				fspc_pkg::REG_RDATA:    s_d.prdata = {24'h0, s_q.rdata};
				fspc_pkg::REG_STATUS: begin
					s_d.prdata = fspc_pkg::ZERO_WORD;
					s_d.prdata[fspc_pkg::ST_BUSY_BIT] = busy;
					s_d.prdata[fspc_pkg::ST_MODE_BIT] = mode;
					s_d.prdata[fspc_pkg::ST_PROT_BIT] = s_q.prot_err;
					s_d.prdata[fspc_pkg::ST_LOCK_BIT] = s_q.lock;
				end
				default:                s_d.prdata = fspc_pkg::ZERO_WORD;
			endcase
		end
		if (mode && irq_s2_q) begin
			s_d.irq_pend = 1'b1;
		end else if (!mode) begin
			s_d.irq_pend = 1'b0;
		end
		case (s_q.state)
			fspc_pkg::FSPC_NORMAL: s_d.cnt = '0;
			fspc_pkg::FSPC_WAIT_HALT: begin
				if (halt_s2_q) begin
					s_d.state = fspc_pkg::FSPC_WAKE;
					s_d.cnt   = '0;
				end
			end
			// bounded halt release
			// Synchroniser latency is taken off so the bound holds from the HALT itself
			fspc_pkg::FSPC_WAKE: begin
				s_d.cnt = s_q.cnt + CW'(1);
				if (s_q.cnt >= CW'(WAKE_CYCLES - fspc_pkg::HALT_SYNC_CLKS - 1)) begin
					s_d.rel   = 1'b1;
					s_d.state = fspc_pkg::FSPC_IDLE;
					s_d.cnt   = '0;
				end
			end
			fspc_pkg::FSPC_IDLE: begin
				s_d.cnt = '0;
				if (wr_acc && paddr == fspc_pkg::REG_CMD) begin
					case (pwdata[7:0])
						fspc_pkg::CMD_WRITE: s_d.state = fspc_pkg::FSPC_WRITE;
						fspc_pkg::CMD_ERASE: s_d.state = fspc_pkg::FSPC_ERASE;
						fspc_pkg::CMD_READ:  s_d.state = fspc_pkg::FSPC_READ;
						default: ;
					endcase
				end
			end
			// command runs for a fixed time
			fspc_pkg::FSPC_WRITE, fspc_pkg::FSPC_ERASE, fspc_pkg::FSPC_READ: begin
				s_d.cnt = s_q.cnt + CW'(1);
				if (s_q.cnt >= CW'(fspc_pkg::OP_CYCLES - 1)) begin
					s_d.state = fspc_pkg::FSPC_IDLE;
					s_d.cmd   = fspc_pkg::CMD_NONE;
					if (s_q.state == fspc_pkg::FSPC_ERASE) begin
						if (s_q.lock) begin
							s_d.prot_err = 1'b1;
						end else begin
							era_we = 1'b1;
						end
					end else if (s_q.state == fspc_pkg::FSPC_WRITE) begin
						if (s_q.lock && mem_q[s_q.addr] != fspc_pkg::BLANK_BYTE
							&& mem_q[s_q.addr] != s_q.wdata) begin
							s_d.prot_err = 1'b1;
						end else begin
							// Flash can only clear bits
							mem_we = 1'b1;
							mem_wd = mem_q[s_q.addr] & s_q.wdata;
						end
					end else begin
						s_d.rdata = mem_q[s_q.addr];
					end
				end
			end
			default: s_d.state = fspc_pkg::FSPC_NORMAL;
		endcase
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '{state: fspc_pkg::FSPC_NORMAL, prdata: fspc_pkg::ZERO_WORD, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// Flash array, no reset; contents are unknown until first erase
	// erase fills block with blank
	always_ff @(posedge pclk) begin
		if (era_we) begin
			for (int i = 0; i < BLOCK_BYTES; i++) begin
				mem_q[blk_base(s_q.addr) + AW'(i)] <= fspc_pkg::BLANK_BYTE;
			end
		end else if (mem_we) begin
			mem_q[mem_wa] <= mem_wd;
		end
	end

	assign prdata       = s_q.prdata;
	assign pready       = 1'b1;
	assign pslverr      = psel && penable && !(paddr inside {fspc_pkg::REG_MODE, fspc_pkg::REG_CMD,
		fspc_pkg::REG_ADDR, fspc_pkg::REG_WDATA, fspc_pkg::REG_STATUS, fspc_pkg::REG_SECURITY,
		fspc_pkg::REG_RDATA});
	assign cpu_stall    = busy;
	assign halt_release = s_q.rel;
	assign irq_pending  = s_q.irq_pend;
	assign irq_ack_ok   = !mode;
	assign pin_hold     = mode;
	assign ram_req      = 1'b0;
endmodule : fspc_ctrl

// ### fspc_ctrl_asserts.sv
// Checker: port-level properties of the flash sequencer
`timescale 1ns/1ps
module fspc_ctrl_asserts #(
	parameter int WAKE_CYCLES = 402
) (
	input wire logic pclk,         // Clock
	input wire logic presetn,      // Reset, low
	input wire logic cpu_halt,     // CPU halted
	input wire logic irq_ack_ok,   // Ack allowed
	input wire logic irq_pending,  // Held request
	input wire logic cpu_stall,    // CPU stalled
	input wire logic halt_release, // Wake pulse
	input wire logic pin_hold,     // Pins frozen
	input wire logic ram_req       // RAM request
);
	// Release bound counted from the HALT itself, synchroniser included
	localparam int WMAX = WAKE_CYCLES;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ram_unused: assert property (ram_req == 1'b0)
		else $error("ram request seen");
	chk_ack_mode: assert property (irq_ack_ok == !pin_hold)
		else $error("ack allowed in mode");
	chk_pend_mode: assert property ($rose(irq_pending) |-> pin_hold)
		else $error("pending outside mode");
	chk_pend_clear: assert property ($fell(pin_hold) |-> ##[0:2] !irq_pending)
		else $error("pending kept after mode");
	chk_stall_len: assert property ($rose(cpu_stall) |-> cpu_stall [*8] ##1 !cpu_stall)
		else $error("stall length wrong");
	chk_stall_pins: assert property (cpu_stall |-> pin_hold && !irq_ack_ok)
		else $error("stall outside mode");
	chk_wake_pulse: assert property (halt_release |=> !halt_release)
		else $error("wake pulse too long");
	chk_wake_mode: assert property (halt_release |-> pin_hold)
		else $error("wake outside mode");
	chk_wake_bound: assert property ($rose(cpu_halt) && pin_hold |-> ##[1:WMAX] halt_release)
		else $error("halt not released");
	cover property ($rose(cpu_stall));
	cover property (halt_release);
	cover property ($rose(irq_pending));
endmodule : fspc_ctrl_asserts
bind fspc_ctrl fspc_ctrl_asserts #(.WAKE_CYCLES(WAKE_CYCLES)) u_chk (.pclk(pclk), .presetn(presetn),
	.cpu_halt(cpu_halt), .irq_ack_ok(irq_ack_ok), .irq_pending(irq_pending), .cpu_stall(cpu_stall),
	.halt_release(halt_release), .pin_hold(pin_hold), .ram_req(ram_req));

// ### fspc_cpu_model.sv
// CPU core model: halts after mode entry, then settles
`timescale 1ns/1ps
module fspc_cpu_model #(
	parameter int SETTLE_CYCLES = 320
) (
	input  wire logic pclk,         // Clock
	input  wire logic presetn,      // Reset, low
	input  wire logic halt_go,      // NOP then HALT
	input  wire logic halt_release, // Wake pulse
	output logic      cpu_halt,     // Halted
	output logic      cmd_ok        // Commands allowed
);
	logic [9:0] wait_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_halt <= 1'b0;
			wait_q   <= '0;
		end else if (halt_release && cpu_halt) begin
			cpu_halt <= 1'b0;
			wait_q   <= 10'(SETTLE_CYCLES);
		end else begin
			if (halt_go)
				cpu_halt <= 1'b1;
			if (wait_q != 0)
				wait_q <= wait_q - 10'h001;
		end
	end
	assign cmd_ok = !cpu_halt && wait_q == 0;
endmodule : fspc_cpu_model

// ### fspc_ctrl_tb.sv
// Testbench: APB stimulus beside a CPU model, queued read checks
`timescale 1ns/1ps
module fspc_ctrl_tb;
	logic        pclk, presetn, psel, penable, pwrite, irq_req, halt_go;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, cpu_halt, irq_ack_ok, irq_pending;
	logic        cpu_stall, halt_release, pin_hold, ram_req, cmd_ok;
	logic [32:0] rq[$];
	logic [15:0] rnd;
	logic [7:0]  d1;
	logic        irq_en;
	int          bad_count, checks_done, wdt_left;
	localparam int WDT_SPAN = 64;
	fspc_ctrl #(
		.WAKE_CYCLES  (4)
	) DUT (
		.pclk         (pclk),
		.presetn      (presetn),
		.psel         (psel),
		.penable      (penable),
		.pwrite       (pwrite),
		.paddr        (paddr),
		.pwdata       (pwdata),
		.prdata       (prdata),
		.pready       (pready),
		.pslverr      (pslverr),
		.cpu_halt     (cpu_halt),
		.irq_req      (irq_req),
		.irq_ack_ok   (irq_ack_ok),
		.irq_pending  (irq_pending),
		.cpu_stall    (cpu_stall),
		.halt_release (halt_release),
		.pin_hold     (pin_hold),
		.ram_req      (ram_req)
	);
	fspc_cpu_model u_cpu (
		.pclk         (pclk),
		.presetn      (presetn),
		.halt_go      (halt_go),
		.halt_release (halt_release),
		.cpu_halt     (cpu_halt),
		.cmd_ok       (cmd_ok)
	);
	function automatic logic [15:0] lfsr(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic check(string nm, logic [32:0] seen, logic [32:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// One APB transfer, held until pready is sampled high
	task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		{psel, penable} <= 2'b00;
	endtask : xfer
	task automatic rd(logic [11:0] a, logic [32:0] e);
		rq.push_back(e);
		xfer(1'b0, a, 32'h0000_0000);
	endtask : rd
	// routine resident in bench
	// Command issue; the CPU must stay stalled until it ends
	task automatic cmd(logic [7:0] a, logic [7:0] c, logic [7:0] d);
		xfer(1'b1, fspc_pkg::REG_ADDR, {24'h0, a});
		xfer(1'b1, fspc_pkg::REG_WDATA, {24'h0, d});
		wdt_left = WDT_SPAN;
		xfer(1'b1, fspc_pkg::REG_CMD, {24'h0, c});
		repeat (2) @(posedge pclk);
		check("stall", {32'h0, cpu_stall}, 33'h1);
		while (cpu_stall !== 1'b0) begin
			@(posedge pclk);
			wdt_left--;
		end
		check("wdt", {32'h0, wdt_left > 0}, 33'h1);
	endtask : cmd
	task automatic summarize();
		$display("Checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// Hang guard, far beyond the fewer than one thousand cycles needed
	initial begin
		repeat (30000) @(posedge pclk);
		bad_count++;
		summarize();
	end
	// Each read completion takes the oldest note
	always @(posedge pclk) begin
		if (psel && penable && !pwrite && pready)
			check("read", {pslverr, prdata}, rq.pop_front());
	end
	initial begin
		{presetn, psel, penable, pwrite, irq_req, halt_go, paddr, pwdata} = '0;
		rnd = 16'hf19e;
		irq_en = 1'b1;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		irq_en = 1'b0;
		xfer(1'b1, fspc_pkg::REG_CMD, 32'h0);
		xfer(1'b1, fspc_pkg::REG_MODE, 32'h1);
		halt_go <= 1'b1;
		@(posedge pclk);
		{halt_go, irq_req} <= 2'b01;
		do @(posedge pclk); while (cpu_halt !== 1'b1);
		do @(posedge pclk); while (cmd_ok !== 1'b1);
		check("pins", {32'h0, pin_hold}, 33'h1);
		check("pend", {31'h0, irq_pending, irq_ack_ok}, 33'h2);
		$display("test mode entry done");
		// Erase from mid-block, then every byte of it reads blank
		cmd(8'h13, fspc_pkg::CMD_ERASE, 8'h00);
		for (int i = 0; i < 16; i++) begin
			cmd(8'h10 + i[7:0], fspc_pkg::CMD_READ, 8'h00);
			rd(fspc_pkg::REG_RDATA, {25'h0, fspc_pkg::BLANK_BYTE});
		end
		rnd = lfsr(rnd);
		d1 = rnd[7:0] & 8'h7f;
		cmd(8'h11, fspc_pkg::CMD_WRITE, d1);
		cmd(8'h11, fspc_pkg::CMD_READ, 8'h00);
		rd(fspc_pkg::REG_RDATA, {25'h0, d1});
		$display("test erase write done");
		xfer(1'b1, fspc_pkg::REG_SECURITY, 32'h1);
		cmd(8'h11, fspc_pkg::CMD_ERASE, 8'h00);
		rd(fspc_pkg::REG_STATUS, 33'h00e);
		xfer(1'b1, fspc_pkg::REG_STATUS, 32'h4);
		cmd(8'h11, fspc_pkg::CMD_WRITE, ~d1);
		rd(fspc_pkg::REG_STATUS, 33'h00e);
		cmd(8'h11, fspc_pkg::CMD_READ, 8'h00);
		rd(fspc_pkg::REG_RDATA, {25'h0, d1});
		rd(12'h020, {1'b1, 32'h0});
		$display("test lock done");
		xfer(1'b1, fspc_pkg::REG_CMD, 32'h0);
		xfer(1'b1, fspc_pkg::REG_MODE, 32'h0);
		repeat (4) @(posedge pclk);
		check("leave", {30'h0, pin_hold, irq_pending, irq_ack_ok}, 33'h1);
		check("ram", {32'h0, ram_req}, 33'h0);
		check("svc", {32'h0, irq_en && irq_ack_ok}, 33'h0);
		$display("test mode exit done");
		summarize();
	end
endmodule : fspc_ctrl_tb
